// ---- core/dsu_uart.sv ----
// Byte-wide asynchronous serial port with transceiver direction control
`timescale 1ns/1ps
`default_nettype none
`include "dsu_uart_regs.svh"

// Notes on behaviour
// RULE1: Bit 7 of offset 3 maps divisor in
// RULE2: Host writes divisor low then high byte
// RULE3: Reference 1.8432 or 7.3728 MHz by option
// RULE4: Divisor twelve 9600, one 115200 baud
// RULE5: Bits 1:0 give length minus five
// RULE6: Bit 2 picks one or two stops
// RULE7: Bits 3..6 give parity and break
// RULE8: Host clears access select after divisor load
// RULE9: Value 0x03 gives 8N1, data visible
// RULE10: Host flushes receiver with two reads
// RULE11: Status bit 0 shows waiting character
// RULE12: Offset 2 reads pending interrupt source
// RULE13: Receive-available source reads with weight 4
// RULE14: RS485 auto mode drives while data pending
// RULE15: Host raises RTS before sending
// RULE16: RTS steers transceiver direction
// RULE17: Status bit 5 shows holding register empty
// RULE18: Host drops RTS after last character
// RULE19: Control bit 3 gates interrupt request
// RULE20: Option selects RS422 or RS485 path
// RULE21: Data and enable regs when access off
module dsu_uart
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host register port
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Jumper options
    input wire logic quadruple_clock_option,
    input wire logic rs485_mode,
    input wire logic auto_driver,
    // Serial line and transceiver
    input wire logic rx_line,
    output logic tx_line,
    output logic driver_enable,
    output logic rts_out,
    output logic irq
);
    // ======================================================
    // Register state
    logic [7:0] div_lo_reg, div_hi_reg, lfc_reg, moc_reg, ien_reg;
    logic [7:0] thr_reg;
    logic thr_full_reg, overrun_reg, par_err_reg, frame_err_reg;
    logic divisor_access_select;
    logic wr_data, rd_data, rd_lsf;
    logic [7:0] iid;
    logic rx_pend, tx_pend;
    dsu_stream_if rxq_in ();
    dsu_stream_if rxq_out ();

    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [7:0] lfc);
        if (lfc[`DSU_LFC_STICK])
            par_bit = ~lfc[`DSU_LFC_EVEN];
        else
            par_bit = (^d) ^ ~lfc[`DSU_LFC_EVEN];
    endfunction

    assign divisor_access_select = lfc_reg[`DSU_LFC_DIV_ACCESS]; // see RULE1
    assign wr_data = reg_wr && reg_addr == `DSU_OFF_DATA
        && !divisor_access_select;
    assign rd_data = reg_rd && reg_addr == `DSU_OFF_DATA
        && !divisor_access_select;
    assign rd_lsf = reg_rd && reg_addr == `DSU_OFF_LSF;
    assign rxq_out.ready = rd_data; // see RULE21

    // ======================================================
    // Host writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_lo_reg <= `DSU_RST_DIV_LO;
            div_hi_reg <= `DSU_RST_BYTE;
            lfc_reg <= `DSU_RST_BYTE;
            moc_reg <= `DSU_RST_BYTE;
            ien_reg <= `DSU_RST_BYTE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `DSU_OFF_DATA:
                    if (divisor_access_select)
                        div_lo_reg <= reg_wdata; // see RULE1
                `DSU_OFF_DIVH:
                    if (divisor_access_select)
                        div_hi_reg <= reg_wdata; // see RULE1
                    else
                        ien_reg <= reg_wdata; // see RULE21
                `DSU_OFF_LFC: lfc_reg <= reg_wdata; // see RULE9
                `DSU_OFF_MOC: moc_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ======================================================
    // Reference clock and 16x sample tick
    logic q1_reg, q2_reg, rx1_reg, rx2_reg;
    logic m1_reg, m2_reg, a1_reg, a2_reg, auto_dir;
    logic [24:0] phase_sum;
    logic [23:0] phase_reg;
    logic [15:0] div_cnt_reg;
    logic os_tick;
    logic ref_tick_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q1_reg <= 1'b0;
            q2_reg <= 1'b0;
            rx1_reg <= 1'b1;
            rx2_reg <= 1'b1;
            m1_reg <= 1'b0;
            m2_reg <= 1'b0;
            a1_reg <= 1'b0;
            a2_reg <= 1'b0;
        end
        else
        begin
            q1_reg <= quadruple_clock_option;
            q2_reg <= q1_reg;
            rx1_reg <= rx_line;
            rx2_reg <= rx1_reg;
            m1_reg <= rs485_mode;
            m2_reg <= m1_reg;
            a1_reg <= auto_driver;
            a2_reg <= a1_reg;
        end
    end

    assign phase_sum = {1'b0, phase_reg}
        + {1'b0, q2_reg ? `DSU_STEP_QUAD : `DSU_STEP_BASE}; // see RULE3
    assign os_tick = ref_tick_reg && (div_cnt_reg <= 16'h0001);
    assign auto_dir = m2_reg && a2_reg; // see RULE20

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase_reg <= 24'h000000;
            ref_tick_reg <= 1'b0;
            div_cnt_reg <= 16'h0000;
        end
        else
        begin
            phase_reg <= phase_sum[23:0];
            ref_tick_reg <= phase_sum[24];
            if (ref_tick_reg)
            begin
                if (div_cnt_reg <= 16'h0001)
                    div_cnt_reg <= {div_hi_reg, div_lo_reg}; // see RULE4
                else
                    div_cnt_reg <= div_cnt_reg - 16'h0001;
            end
        end
    end

    // ======================================================
    // Transmitter
    dsu_uart_pkg::dsu_tx_t tx_st_reg;
    logic [3:0] tx_tick_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_sh_reg;
    logic tx_stop2_reg;
    logic [2:0] last_bit;

    assign last_bit = {1'b1, lfc_reg[1:0]}; // see RULE5

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_st_reg <= dsu_uart_pkg::TX_IDLE;
            tx_tick_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= `DSU_RST_BYTE;
            tx_stop2_reg <= 1'b0;
            thr_reg <= `DSU_RST_BYTE;
            thr_full_reg <= 1'b0;
        end
        else
        begin
            if (os_tick)
            begin
                tx_tick_reg <= tx_tick_reg + 4'h1;
                case (tx_st_reg)
                    dsu_uart_pkg::TX_IDLE:
                        if (thr_full_reg)
                        begin
                            tx_sh_reg <= thr_reg;
                            thr_full_reg <= 1'b0;
                            tx_tick_reg <= 4'h0;
                            tx_st_reg <= dsu_uart_pkg::TX_START;
                        end
                    dsu_uart_pkg::TX_START:
                        if (tx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            tx_bit_reg <= 3'h0;
                            tx_st_reg <= dsu_uart_pkg::TX_DATA;
                        end
                    dsu_uart_pkg::TX_DATA:
                        if (tx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                            tx_stop2_reg <= lfc_reg[`DSU_LFC_STOP2];
                            if (tx_bit_reg == last_bit)
                                tx_st_reg <= lfc_reg[`DSU_LFC_PAR] ?
                                    dsu_uart_pkg::TX_PAR :
                                    dsu_uart_pkg::TX_STOP; // see RULE7
                        end
                    dsu_uart_pkg::TX_PAR:
                        if (tx_tick_reg == `DSU_OVERSAMPLE)
                            tx_st_reg <= dsu_uart_pkg::TX_STOP;
                    dsu_uart_pkg::TX_STOP:
                        if (tx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            tx_stop2_reg <= 1'b0; // see RULE6
                            if (!tx_stop2_reg)
                                tx_st_reg <= dsu_uart_pkg::TX_IDLE;
                        end
                    default: tx_st_reg <= dsu_uart_pkg::TX_IDLE;
                endcase
            end
            if (wr_data)
            begin
                thr_reg <= reg_wdata; // see RULE21
                thr_full_reg <= 1'b1;
            end
        end
    end

    // Parity of the character held in the shifter at its load
    logic [7:0] tx_word_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_word_reg <= `DSU_RST_BYTE;
        else if (os_tick && tx_st_reg == dsu_uart_pkg::TX_IDLE
                 && thr_full_reg)
            tx_word_reg <= thr_reg & (8'hFF >> (3'h3 - lfc_reg[1:0]));
    end

    // ======================================================
    // Receiver
    dsu_uart_pkg::dsu_rx_t rx_st_reg;
    logic [3:0] rx_tick_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_push_reg, rx_pe_reg;
    logic [7:0] rx_word;

    assign rx_word = rx_sh_reg >> (3'h3 - lfc_reg[1:0]);
    assign rxq_in.data = rx_word;
    assign rxq_in.valid = rx_push_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_st_reg <= dsu_uart_pkg::RX_IDLE;
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= `DSU_RST_BYTE;
            rx_push_reg <= 1'b0;
            rx_pe_reg <= 1'b0;
        end
        else
        begin
            rx_push_reg <= 1'b0;
            if (os_tick)
            begin
                rx_tick_reg <= rx_tick_reg + 4'h1;
                case (rx_st_reg)
                    dsu_uart_pkg::RX_IDLE:
                        if (!rx2_reg)
                        begin
                            rx_tick_reg <= 4'h0;
                            rx_st_reg <= dsu_uart_pkg::RX_START;
                        end
                    dsu_uart_pkg::RX_START:
                        if (tx_tick_sync(rx_tick_reg))
                        begin
                            rx_tick_reg <= 4'h0;
                            rx_bit_reg <= 3'h0;
                            rx_st_reg <= rx2_reg ? dsu_uart_pkg::RX_IDLE
                                                 : dsu_uart_pkg::RX_DATA;
                        end
                    dsu_uart_pkg::RX_DATA:
                        if (rx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            rx_sh_reg <= {rx2_reg, rx_sh_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == last_bit)
                                rx_st_reg <= lfc_reg[`DSU_LFC_PAR] ?
                                    dsu_uart_pkg::RX_PAR :
                                    dsu_uart_pkg::RX_STOP;
                        end
                    dsu_uart_pkg::RX_PAR:
                        if (rx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            rx_pe_reg <= rx2_reg
                                != par_bit(rx_word, lfc_reg); // see RULE7
                            rx_st_reg <= dsu_uart_pkg::RX_STOP;
                        end
                    dsu_uart_pkg::RX_STOP:
                        if (rx_tick_reg == `DSU_OVERSAMPLE)
                        begin
                            rx_push_reg <= 1'b1;
                            rx_st_reg <= dsu_uart_pkg::RX_IDLE;
                        end
                    default: rx_st_reg <= dsu_uart_pkg::RX_IDLE;
                endcase
            end
        end
    end

    function automatic logic tx_tick_sync(input logic [3:0] t);
        tx_tick_sync = (t == `DSU_MID_SAMPLE);
    endfunction

    dsu_byte_buf u_rxq
    (
        .clk(clk),
        .rst(rst),
        .up(rxq_in),
        .dn(rxq_out)
    );

    // Sticky errors; a new error wins over the clearing status read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overrun_reg <= 1'b0;
            par_err_reg <= 1'b0;
            frame_err_reg <= 1'b0;
        end
        else
        begin
            if (rd_lsf)
            begin
                overrun_reg <= 1'b0;
                par_err_reg <= 1'b0;
                frame_err_reg <= 1'b0;
            end
            if (rx_push_reg && !rxq_in.ready)
                overrun_reg <= 1'b1;
            if (rx_push_reg && rx_pe_reg)
                par_err_reg <= 1'b1;
            if (os_tick && rx_st_reg == dsu_uart_pkg::RX_STOP
                && rx_tick_reg == `DSU_OVERSAMPLE && !rx2_reg)
                frame_err_reg <= 1'b1;
        end
    end

    // ======================================================
    // Interrupt source, read data and line outputs
    assign rx_pend = rxq_out.valid && ien_reg[`DSU_IEN_RX];
    assign tx_pend = !thr_full_reg && ien_reg[`DSU_IEN_TX];
    assign iid = rx_pend ? `DSU_IID_RXA : // see RULE13
                 tx_pend ? `DSU_IID_TXE : `DSU_IID_NONE;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= `DSU_RST_BYTE;
        else if (reg_rd)
        begin
            case (reg_addr)
                `DSU_OFF_DATA:
                    reg_rdata <= divisor_access_select ? div_lo_reg
                        : rxq_out.data;
                `DSU_OFF_DIVH:
                    reg_rdata <= divisor_access_select ? div_hi_reg
                        : ien_reg;
                `DSU_OFF_IID: reg_rdata <= iid; // see RULE12
                `DSU_OFF_LFC: reg_rdata <= lfc_reg;
                `DSU_OFF_MOC: reg_rdata <= moc_reg;
                `DSU_OFF_LSF:
                    reg_rdata <= {1'b0,
                        !thr_full_reg && tx_st_reg == dsu_uart_pkg::TX_IDLE,
                        !thr_full_reg, // see RULE17
                        1'b0, frame_err_reg, par_err_reg, overrun_reg,
                        rxq_out.valid}; // see RULE11
                default: reg_rdata <= `DSU_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_line <= 1'b1;
            driver_enable <= 1'b0;
            rts_out <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            tx_line <= !lfc_reg[`DSU_LFC_BREAK] && (
                tx_st_reg == dsu_uart_pkg::TX_DATA ? tx_sh_reg[0] :
                tx_st_reg == dsu_uart_pkg::TX_PAR ?
                    par_bit(tx_word_reg, lfc_reg) :
                tx_st_reg != dsu_uart_pkg::TX_START);
            rts_out <= moc_reg[`DSU_MOC_RTS]; // see RULE15
            if (auto_dir)
                driver_enable <= thr_full_reg
                    || tx_st_reg != dsu_uart_pkg::TX_IDLE; // see RULE14
            else
                driver_enable <= moc_reg[`DSU_MOC_RTS]; // see RULE16
            irq <= moc_reg[`DSU_MOC_GATE]
                && (rx_pend || tx_pend); // see RULE19
        end
    end

    // ======================================================
    // Checks
    a_div_low_load: assert property ( // see RULE1
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `DSU_OFF_DATA && divisor_access_select
        |=> div_lo_reg == $past(reg_wdata) && !$rose(thr_full_reg))
        else $error("divisor low byte not loaded");
    a_div_high_guard: assert property ( // see RULE21
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `DSU_OFF_DIVH && !divisor_access_select
        |=> $stable(div_hi_reg))
        else $error("divisor changed with access off");
    a_lfc_write: assert property ( // see RULE9
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `DSU_OFF_LFC && reg_wdata == 8'h03
        |=> !divisor_access_select && lfc_reg[2:0] == 3'h3 && !lfc_reg[3])
        else $error("line control value not applied");
    a_ready_flag: assert property ( // see RULE11
        @(posedge clk) disable iff (rst)
        rd_lsf |=> reg_rdata[0] == $past(rxq_out.valid))
        else $error("data ready flag wrong");
    a_thr_empty: assert property ( // see RULE17
        @(posedge clk) disable iff (rst)
        wr_data && tx_st_reg != dsu_uart_pkg::TX_IDLE
        ##1 tx_st_reg != dsu_uart_pkg::TX_IDLE
        ##1 rd_lsf && tx_st_reg != dsu_uart_pkg::TX_IDLE |=> !reg_rdata[5])
        else $error("holding empty after write");
    a_iid_rx: assert property ( // see RULE13
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `DSU_OFF_IID && rx_pend
        |=> reg_rdata == `DSU_IID_RXA)
        else $error("receive source not reported");
    a_auto_drive: assert property ( // see RULE14
        @(posedge clk) disable iff (rst)
        auto_dir && thr_full_reg |=> driver_enable)
        else $error("driver not enabled in auto mode");
    a_rts_direction: assert property ( // see RULE16
        @(posedge clk) disable iff (rst)
        !auto_dir |=> driver_enable == $past(moc_reg[`DSU_MOC_RTS]))
        else $error("direction does not follow RTS");
    a_irq_gate: assert property ( // see RULE19
        @(posedge clk) disable iff (rst)
        !moc_reg[`DSU_MOC_GATE] |=> !irq)
        else $error("interrupt passed closed gate");
    a_tx_start: assert property (@(posedge clk) disable iff (rst)
        tx_st_reg == dsu_uart_pkg::TX_START && !lfc_reg[`DSU_LFC_BREAK]
        |=> !tx_line)
        else $error("start bit not driven low");
endmodule
`default_nettype wire

// ---- core/dsu_uart_regs.svh ----
// Register offsets, field positions, reset values and rate constants
`ifndef DSU_UART_REGS_SVH
`define DSU_UART_REGS_SVH

// ==========================================================
// Register offsets
`define DSU_OFF_DATA 3'h0
`define DSU_OFF_DIVH 3'h1
`define DSU_OFF_IID 3'h2
`define DSU_OFF_LFC 3'h3
`define DSU_OFF_MOC 3'h4
`define DSU_OFF_LSF 3'h5

// ==========================================================
// Field positions
`define DSU_LFC_DIV_ACCESS 7
`define DSU_LFC_BREAK 6
`define DSU_LFC_STICK 5
`define DSU_LFC_EVEN 4
`define DSU_LFC_PAR 3
`define DSU_LFC_STOP2 2
`define DSU_MOC_RTS 1
`define DSU_MOC_GATE 3
`define DSU_IEN_RX 0
`define DSU_IEN_TX 1

// ==========================================================
// Reset values and answers
`define DSU_RST_BYTE 8'h00
`define DSU_RST_DIV_LO 8'h0C
`define DSU_IID_NONE 8'h01
`define DSU_IID_TXE 8'h02
`define DSU_IID_RXA 8'h04

// ==========================================================
// Reference clock from a 50 MHz system clock: phase step per
// cycle is F_ref * 2^24 / 50e6 (1.8432 MHz and 7.3728 MHz)
`define DSU_REF_HZ_BASE 1843200
`define DSU_REF_HZ_QUAD 7372800
`define DSU_SYS_HZ 50000000
`define DSU_STEP_BASE 24'h096FEB
`define DSU_STEP_QUAD 24'h25BFAD
`define DSU_OVERSAMPLE 4'hF
`define DSU_MID_SAMPLE 4'h7

`endif

// ---- core/dsu_uart_pkg.sv ----
// Types shared by the serial port modules
`default_nettype none
package dsu_uart_pkg;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dsu_tx_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dsu_rx_t;
endpackage
`default_nettype wire

// ---- core/dsu_stream_if.sv ----
// Byte stream with valid and ready between port modules
`timescale 1ns/1ps
`default_nettype none
interface dsu_stream_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- core/dsu_byte_buf.sv ----
// Two-entry receive buffer
`timescale 1ns/1ps
`default_nettype none
module dsu_byte_buf
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling and draining sides
    dsu_stream_if.snk up,
    dsu_stream_if.src dn
);
    logic [7:0] mem [0:1];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign up.ready = (count_reg != 2'h2);
    assign dn.valid = (count_reg != 2'h0);
    assign dn.data = mem[rd_ptr_reg];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= up.data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    a_buf_bound: assert property (@(posedge clk) disable iff (rst)
        count_reg <= 2'h2)
        else $error("buffer count exceeds two");
endmodule
`default_nettype wire

// ---- testbench/dsu_remote_node.sv ----
// Remote serial node model facing the port's line pins
`timescale 1ns/1ps
`default_nettype none
module dsu_remote_node
#(
    parameter real BIT_NS = 8680.6
)
(
    // Line pins
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got = 8'h00;
    int got_count = 0;

    initial rx_line = 1'b1;

    // ==========================================
    // Send one character: start, LSB first, stop
    task automatic send(input logic [7:0] b);
        rx_line = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++)
        begin
            rx_line = b[i];
            #(BIT_NS);
        end
        rx_line = 1'b1;
        #(BIT_NS);
    endtask

    // ==========================================
    // Mid-bit capture; counted only with a good stop
    always
    begin
        @(negedge tx_line);
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++)
        begin
            got[i] = tx_line;
            #(BIT_NS);
        end
        if (tx_line === 1'b1)
            got_count++;
    end
endmodule
`default_nettype wire

// ---- testbench/dsu_uart_tb_top.sv ----
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module dsu_uart_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic quad = 1'b0;
    logic rs485_mode = 1'b0;
    logic auto_driver = 1'b0;
    logic [7:0] v;
    int bad_count = 0;
    int tests_run = 0;
    wire [7:0] reg_rdata;
    wire rx_line;
    wire tx_line;
    wire driver_enable;
    wire rts_out;
    wire irq;

    always #10 clk = ~clk;

    dsu_uart i_dsu_uart (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .quadruple_clock_option(quad),
        .rs485_mode(rs485_mode), .auto_driver(auto_driver),
        .rx_line(rx_line), .tx_line(tx_line),
        .driver_enable(driver_enable), .rts_out(rts_out), .irq(irq));
    dsu_remote_node i_dsu_remote_node (.tx_line(tx_line),
        .rx_line(rx_line));

    // ==========================================
    // Register port cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
    task automatic poll(input int b, output logic [7:0] s);
        s = 8'h00;
        for (int n = 0; n < 3000 && s[b] !== 1'b1; n++)
            rd(3'h5, s);
    endtask
    // Divisor load then 8N1 framing
    task automatic setup(input logic [7:0] dl);
        wr(3'h3, 8'h80);
        wr(3'h0, dl);
        wr(3'h1, 8'h00);
        rd(3'h0, v);
        `CHK(v, dl)
        wr(3'h3, 8'h03);
    endtask
    task automatic tx_byte(input logic [7:0] d);
        int c;
        c = i_dsu_remote_node.got_count;
        wr(3'h0, d);
        for (int n = 0; n < 8000 && i_dsu_remote_node.got_count == c; n++)
            @(posedge clk);
        `CHK(i_dsu_remote_node.got, d)
    endtask

    // ==========================================
    // Scenarios
    task automatic t_init();
        rd(3'h3, v);
        `CHK(v, 8'h00)
        setup(8'h01);
        rd(3'h3, v);
        `CHK(v, 8'h03)
        rd(3'h0, v);
        rd(3'h0, v);
        rd(3'h2, v);
        `CHK(v, 8'h01)
        rd(3'h6, v);
        `CHK(v, 8'h00)
    endtask
    task automatic t_tx();
        wr(3'h4, 8'h02);
        @(posedge clk);
        #1 `CHK({rts_out, driver_enable}, 2'b11)
        tx_byte(8'hA5);
        poll(5, v);
        `CHK(v[5], 1'b1)
        wr(3'h4, 8'h00);
        @(posedge clk);
        #1 `CHK(driver_enable, 1'b0)
    endtask
    task automatic t_rx();
        wr(3'h1, 8'h01);
        wr(3'h4, 8'h08);
        fork
            i_dsu_remote_node.send(8'h3C);
        join_none
        poll(0, v);
        `CHK(v[0], 1'b1)
        rd(3'h2, v);
        `CHK(v, 8'h04)
        `CHK(irq, 1'b1)
        rd(3'h0, v);
        `CHK(v, 8'h3C)
        rd(3'h5, v);
        `CHK(v[0], 1'b0)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_quad_auto();
        @(posedge clk);
        quad <= 1'b1;
        setup(8'h04);
        tx_byte(8'h5A);
        rs485_mode <= 1'b1;
        auto_driver <= 1'b1;
        wr(3'h0, 8'hC3);
        repeat (3) @(posedge clk);
        #1 `CHK(driver_enable, 1'b1)
        repeat (100) @(posedge clk);
        wr(3'h0, 8'h96);
        rd(3'h5, v);
        `CHK(v[5], 1'b0)
        repeat (9500) @(posedge clk);
        #1 `CHK(i_dsu_remote_node.got, 8'h96)
        `CHK(driver_enable, 1'b0)
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_init();
        t_tx();
        t_rx();
        t_quad_auto();
        give_verdict();
    end

    initial
    begin
        #1500000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
